// File: rtl/iep_top.sv
/*
 * iep_top: interrupt enable and priority registers behind an AXI4-Lite
 * slave, with source synchronisers, priority selection and sticky event
 * status driving one level interrupt.
 * Assumes source request pins are asynchronous levels, one clock MCLK.
 */
// Contract
// - enable bit 5 gates timer 2
// - enable bit 1 gates timer 0
// - enable bit 6 gates counter array
// - enable resets zero, bit-addressable
// - priority bit 6: counter array level low
// - priority bit 5: timer 2 level low
// - priority bit 4: serial level low
// - priority bit 3: timer 1 level low
// - priority bit 2: external 1 level low
// - priority bit 1: timer 0 level low
// - priority bit 7 reserved, never set
// - priority resets low bits zero, bit-addressable
`timescale 1ns/1ns
`default_nettype none

module iep_top (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic [6:0]  IRQ_SRC,
   output var  logic        CORE_REQ,
   output var  logic [1:0]  CORE_LEVEL,
   output var  logic [2:0]  CORE_SOURCE,
   output var  logic        IRQ,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   // register state
   logic [7:0] interrupt_enable;
   logic [6:0] interrupt_priority_low;
   logic [6:0] interrupt_priority_high;
   logic [6:0] status;
   logic [6:0] mask;
   logic [7:0] next_interrupt_enable;
   logic [6:0] next_interrupt_priority_low;
   logic [6:0] next_interrupt_priority_high;
   logic [6:0] next_status;
   logic [6:0] next_mask;
   logic       next_irq;

   // write channel state
   logic [7:0]  aw_addr;
   logic        aw_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        w_held;
   logic [7:0]  next_aw_addr;
   logic        next_aw_held;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_w_held;
   logic        next_awready;
   logic        next_wready;
   logic        next_bvalid;
   logic [1:0]  next_bresp;

   // read channel state
   logic        next_arready;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   logic [6:0]        src_sync;
   logic [6:0]        src_prev;
   logic [6:0]        src_rise;
   logic              do_write;
   logic              wr_hit;
   iep_pkg::iep_req_s core_req;

   iep_sync #(
      .W (iep_pkg::NSRC)
   ) u_sync (
      .clk (MCLK),
      .rst (RST),
      .d   (IRQ_SRC),
      .q   (src_sync)
   );

   iep_prio_select u_sel (
      .clk       (MCLK),
      .rst       (RST),
      .pending   (src_sync),
      .enable    (interrupt_enable),
      .prio_low  (interrupt_priority_low),
      .prio_high (interrupt_priority_high),
      .req       (core_req)
   );

   // write fires once address and data are both held and no answer waits
   assign do_write = aw_held && w_held && !S_AXI_BVALID;
   assign src_rise = src_sync & ~src_prev;

   always_comb begin
      wr_hit = 1'b0;
      unique case (aw_addr)
         iep_pkg::OFS_ENABLE,
         iep_pkg::OFS_PRIO_LOW,
         iep_pkg::OFS_PRIO_HIGH,
         iep_pkg::OFS_STATUS,
         iep_pkg::OFS_MASK,
         iep_pkg::OFS_BIT_OP,
         iep_pkg::OFS_CORE: wr_hit = 1'b1;
         default:           wr_hit = 1'b0;
      endcase
   end

   // AXI write channel
   always_comb begin
      next_aw_addr = aw_addr;
      next_aw_held = aw_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_w_held  = w_held;
      next_bvalid  = S_AXI_BVALID;
      next_bresp   = S_AXI_BRESP;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_aw_addr = S_AXI_AWADDR;
         next_aw_held = 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_w_data = S_AXI_WDATA;
         next_w_strb = S_AXI_WSTRB;
         next_w_held = 1'b1;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_hit ? iep_pkg::RESP_OKAY : iep_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         next_bvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   // register updates
   always_comb begin
      logic [2:0] bidx;
      logic [1:0] bsel;
      logic       bval;
      bidx = w_data[iep_pkg::BOP_IDX_LSB +: 3];
      bsel = w_data[iep_pkg::BOP_SEL_LSB +: 2];
      bval = w_data[iep_pkg::BOP_VAL];
      next_interrupt_enable        = interrupt_enable;
      next_interrupt_priority_low  = interrupt_priority_low;
      next_interrupt_priority_high = interrupt_priority_high;
      next_mask                    = mask;
      next_status                  = status;
      if (do_write && w_strb[0]) begin
         unique case (aw_addr)
            iep_pkg::OFS_ENABLE:
               next_interrupt_enable = w_data[7:0];
            iep_pkg::OFS_PRIO_LOW:
               next_interrupt_priority_low = w_data[6:0];
            iep_pkg::OFS_PRIO_HIGH:
               next_interrupt_priority_high = w_data[6:0];
            iep_pkg::OFS_MASK:
               next_mask = w_data[6:0];
            iep_pkg::OFS_STATUS:
               next_status = status & ~w_data[6:0];
            iep_pkg::OFS_BIT_OP: begin
               unique case (iep_pkg::iep_bop_e'(bsel))
                  iep_pkg::BOP_ENABLE:
                     next_interrupt_enable[bidx] = bval;
                  iep_pkg::BOP_PRIO_LOW:
                     if (bidx != 3'h7) begin
                        next_interrupt_priority_low[bidx] = bval;
                     end
                  iep_pkg::BOP_PRIO_HIGH:
                     if (bidx != 3'h7) begin
                        next_interrupt_priority_high[bidx] = bval;
                     end
                  iep_pkg::BOP_NONE: ;
               endcase
            end
            default: ;
         endcase
      end
      // a new edge beats a same-cycle clear
      next_status = next_status | src_rise;
      next_irq    = |(next_status & next_mask);
   end

   // AXI read channel
   always_comb begin
      next_rvalid  = S_AXI_RVALID;
      next_rdata   = S_AXI_RDATA;
      next_rresp   = S_AXI_RRESP;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         next_rvalid  = 1'b1;
         next_rresp   = iep_pkg::RESP_OKAY;
         unique case (S_AXI_ARADDR)
            iep_pkg::OFS_ENABLE:
               next_rdata = {24'h000000, interrupt_enable};
            iep_pkg::OFS_PRIO_LOW:
               next_rdata = {25'h0000000, interrupt_priority_low};
            iep_pkg::OFS_PRIO_HIGH:
               next_rdata = {25'h0000000, interrupt_priority_high};
            iep_pkg::OFS_STATUS:
               next_rdata = {25'h0000000, status};
            iep_pkg::OFS_MASK:
               next_rdata = {25'h0000000, mask};
            iep_pkg::OFS_BIT_OP:
               next_rdata = 32'h00000000;
            iep_pkg::OFS_CORE:
               next_rdata = {26'h0000000, core_req};
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = iep_pkg::RESP_SLVERR;
            end
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         next_rvalid  = 1'b0;
      end
      // ready after reset too, not only after a first answer
      next_arready = !next_rvalid;
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         interrupt_enable        <= iep_pkg::RST_ENABLE;
         interrupt_priority_low  <= iep_pkg::RST_PRIO;
         interrupt_priority_high <= iep_pkg::RST_PRIO;
         status                  <= iep_pkg::RST_STATUS;
         mask                    <= iep_pkg::RST_MASK;
         src_prev                <= 7'h00;
         IRQ                     <= 1'b0;
         aw_addr                 <= 8'h00;
         aw_held                 <= 1'b0;
         w_data                  <= 32'h00000000;
         w_strb                  <= 4'h0;
         w_held                  <= 1'b0;
         S_AXI_AWREADY           <= 1'b0;
         S_AXI_WREADY            <= 1'b0;
         S_AXI_BVALID            <= 1'b0;
         S_AXI_BRESP             <= 2'b00;
         S_AXI_ARREADY           <= 1'b0;
         S_AXI_RVALID            <= 1'b0;
         S_AXI_RDATA             <= 32'h00000000;
         S_AXI_RRESP             <= 2'b00;
         CORE_REQ                <= 1'b0;
         CORE_LEVEL              <= 2'b00;
         CORE_SOURCE             <= 3'h0;
      end else begin
         interrupt_enable        <= next_interrupt_enable;
         interrupt_priority_low  <= next_interrupt_priority_low;
         interrupt_priority_high <= next_interrupt_priority_high;
         status                  <= next_status;
         mask                    <= next_mask;
         src_prev                <= src_sync;
         IRQ                     <= next_irq;
         aw_addr                 <= next_aw_addr;
         aw_held                 <= next_aw_held;
         w_data                  <= next_w_data;
         w_strb                  <= next_w_strb;
         w_held                  <= next_w_held;
         S_AXI_AWREADY           <= next_awready;
         S_AXI_WREADY            <= next_wready;
         S_AXI_BVALID            <= next_bvalid;
         S_AXI_BRESP             <= next_bresp;
         S_AXI_ARREADY           <= next_arready;
         S_AXI_RVALID            <= next_rvalid;
         S_AXI_RDATA             <= next_rdata;
         S_AXI_RRESP             <= next_rresp;
         CORE_REQ                <= core_req.valid;
         CORE_LEVEL              <= core_req.level;
         CORE_SOURCE             <= core_req.source;
      end
   end

endmodule : iep_top

`default_nettype wire

// File: rtl/iep_pkg.sv
/*
 * iep_pkg: register map, field positions, reset values and carrier types
 * for the interrupt enable and priority block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package iep_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NSRC   = 7;

   // register byte addresses
   localparam logic [7:0] OFS_ENABLE    = 8'ha8;
   localparam logic [7:0] OFS_PRIO_LOW  = 8'hb8;
   localparam logic [7:0] OFS_PRIO_HIGH = 8'hb4;
   localparam logic [7:0] OFS_STATUS    = 8'hc0;
   localparam logic [7:0] OFS_MASK      = 8'hc4;
   localparam logic [7:0] OFS_BIT_OP    = 8'hc8;
   localparam logic [7:0] OFS_CORE      = 8'hcc;

   // reset values
   localparam logic [7:0] RST_ENABLE    = 8'h00;
   localparam logic [6:0] RST_PRIO      = 7'h00;
   localparam logic [6:0] RST_STATUS    = 7'h00;
   localparam logic [6:0] RST_MASK      = 7'h00;

   // enable register fields, source index = bit position
   localparam int BIT_EXT0   = 0;
   localparam int BIT_TIMER0 = 1;
   localparam int BIT_EXT1   = 2;
   localparam int BIT_TIMER1 = 3;
   localparam int BIT_SERIAL = 4;
   localparam int BIT_TIMER2 = 5;
   localparam int BIT_CARRAY = 6;
   localparam int BIT_GLOBAL = 7;

   // bit operation register fields
   localparam int BOP_IDX_LSB = 0;
   localparam int BOP_SEL_LSB = 3;
   localparam int BOP_VAL     = 8;

   // bit operation targets
   typedef enum logic [1:0] {
      BOP_ENABLE    = 2'b00,
      BOP_PRIO_LOW  = 2'b01,
      BOP_PRIO_HIGH = 2'b10,
      BOP_NONE      = 2'b11
   } iep_bop_e;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // request offered to the core
   typedef struct packed {
      logic       valid;
      logic [1:0] level;
      logic [2:0] source;
   } iep_req_s;

endpackage : iep_pkg

`default_nettype wire

// File: rtl/iep_sync.sv
/*
 * iep_sync: two-flop synchroniser for a vector of level inputs.
 * Assumes each bit is a slow level; no bus coherence across bits.
 */
`timescale 1ns/1ns
`default_nettype none

module iep_sync #(
   parameter int W = 7
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : iep_sync

`default_nettype wire

// File: rtl/iep_prio_select.sv
/*
 * iep_prio_select: gates pending sources by their enables and picks the
 * one with the highest two-bit level; the result is registered.
 * Assumes synchronised request levels on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module iep_prio_select (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [6:0]        pending,
   input  wire logic [7:0]        enable,
   input  wire logic [6:0]        prio_low,
   input  wire logic [6:0]        prio_high,
   output var  iep_pkg::iep_req_s req
);

   iep_pkg::iep_req_s next_req;
   logic [6:0]        gated;

   always_comb begin
      logic [1:0] lvl;
      lvl      = 2'b00;
      next_req = '0;
      gated = enable[iep_pkg::BIT_GLOBAL] ? (pending & enable[6:0]) : 7'h00;
      // lowest index wins a tie, so scan downward with >=
      for (int i = iep_pkg::NSRC - 1; i >= 0; i--) begin
         // high and low bits form the level
         lvl = {prio_high[i], prio_low[i]};
         if (gated[i] && (!next_req.valid || lvl >= next_req.level)) begin
            next_req.valid  = 1'b1;
            next_req.level  = lvl;
            next_req.source = 3'(i);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req <= '0;
      end else begin
         req <= next_req;
      end
   end

endmodule : iep_prio_select

`default_nettype wire

// File: bench/iep_core_model.sv
/*
 iep_core_model: the cpu core side that samples the request lines.
 Assumes the core looks at the request once per MCLK edge.
*/
`timescale 1ns/1ns
`default_nettype none
module iep_core_model (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              req,
   input  wire logic [1:0]        level,
   input  wire logic [2:0]        source,
   output var  iep_pkg::iep_req_s seen
);
   // core latches whatever stands; it never drops a request itself
   always_ff @(posedge mclk) begin
      if (rst) seen <= '0;
      else seen <= '{valid: req, level: level, source: source};
   end
endmodule : iep_core_model
`default_nettype wire

// File: bench/iep_properties.sv
/*
 iep_props: bus and request checks on the iep_top ports.
 Assumes the bench holds IRQ_SRC steady between changes.
*/
`timescale 1ns/1ns
`default_nettype none
module iep_props (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic [6:0]  IRQ_SRC,
   input wire logic        CORE_REQ,
   input wire logic [2:0]  CORE_SOURCE,
   input wire logic        IRQ,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence s_wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_b_wait;
      S_AXI_BVALID && !S_AXI_BREADY;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_take |-> ##[1:3] S_AXI_BVALID)
      else $error("write answer late");
   AST_B_HOLD: assert property (s_b_wait |=> S_AXI_BVALID
      && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read dropped");
   AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY
      |-> ##[1:2] S_AXI_RVALID) else $error("read answer late");
   AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("address taken during read answer");
   // pending pin must stand behind any request
   AST_REQ_CAUSE: assert property (CORE_REQ |->
      |(($past(IRQ_SRC, 3) | $past(IRQ_SRC, 4) | $past(IRQ_SRC, 5))
      & (7'h01 << CORE_SOURCE))) else $error("request without source");
   AST_SRC_RANGE: assert property (CORE_REQ |-> CORE_SOURCE <= 3'h6)
      else $error("source index out of range");
   AST_RST_QUIET: assert property ($fell(RST) |-> !CORE_REQ && !IRQ
      && !S_AXI_BVALID && !S_AXI_RVALID) else $error("outputs after reset");
endmodule : iep_props
bind iep_top iep_props u_props (.MCLK, .RST, .IRQ_SRC, .CORE_REQ,
   .CORE_SOURCE, .IRQ, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
   .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
   .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
   .S_AXI_RREADY);
`default_nettype wire

// File: bench/tb.sv
/*
 tb: directed bench for iep_top over AXI4-Lite with a core model.
 Assumes readies come back after each answer; one clock MCLK.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic              mclk = 0, rst = 1;
   logic [6:0]        src = '0;
   logic [7:0]        awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rdata;
   logic              awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
   logic              awr, wr, bv, arr, rv, req, irq;
   logic [1:0]        bresp, rresp, lvl;
   logic [2:0]        srcn;
   iep_pkg::iep_req_s seen;
   int                n_mismatch = 0, tests_run = 0;
   always #25 mclk = ~mclk;
   iep_top DUT (.MCLK(mclk), .RST(rst), .IRQ_SRC(src), .CORE_REQ(req),
      .CORE_LEVEL(lvl), .CORE_SOURCE(srcn), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(brdy), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy));
   iep_core_model u_core (.mclk(mclk), .rst(rst), .req(req), .level(lvl),
      .source(srcn), .seen(seen));
   task automatic stop_test;
      $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic sig(input int k);
      case (k)
         0: return awr & wr;
         1: return bv;
         2: return arr;
         default: return rv;
      endcase
   endfunction : sig
   // ready is a register, so its level at the negedge is the edge value
   task automatic wait_on(input int k);
      int n;
      n = 0;
      @(negedge mclk);
      while (sig(k) !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_mismatch++;
            stop_test();
         end
         @(negedge mclk);
      end
   endtask : wait_on
   // ready is raised one cycle late so the slave has to hold its answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw_go, w_go, aw_done, w_done;
      int   n;
      n = 0;
      aw_done = 0;
      w_done = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      // each channel lets go at the edge that takes it
      while (!(aw_done && w_done)) begin
         @(negedge mclk);
         aw_go = !aw_done && (awr === 1'b1);
         w_go = !w_done && (wr === 1'b1);
         n++;
         if (n > 50) begin
            n_mismatch++;
            stop_test();
         end
         @(posedge mclk);
         if (aw_go) awv <= 0;
         if (w_go) wv <= 0;
         aw_done = aw_done || aw_go;
         w_done = w_done || w_go;
      end
      wait_on(1);
      @(posedge mclk);
      brdy <= 1;
      wait_on(1);
      r = bresp;
      @(posedge mclk);
      brdy <= 0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arv <= 1;
      wait_on(2);
      @(posedge mclk);
      arv <= 0;
      wait_on(3);
      @(posedge mclk);
      rrdy <= 1;
      wait_on(3);
      d = rdata;
      r = rresp;
      @(posedge mclk);
      rrdy <= 0;
   endtask : axi_rd
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
   endtask : w
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(d, e);
   endtask : rdchk
   task automatic t_reset;
      rdchk(iep_pkg::OFS_ENABLE, 32'(iep_pkg::RST_ENABLE));
      rdchk(iep_pkg::OFS_PRIO_LOW, 32'h00);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_gate;
      @(posedge mclk);
      src <= 7'h7f;
      for (int i = 0; i < 7; i++) begin
         w(iep_pkg::OFS_ENABLE, 32'h80 | (32'h1 << i));
         repeat (5) @(posedge mclk);
         chk(32'({seen.valid, seen.source}), 32'({1'b1, 3'(i)}));
         w(iep_pkg::OFS_ENABLE, 32'h1 << i);
         repeat (5) @(posedge mclk);
         chk(32'(seen.valid), 32'h0);
      end
      $display("t_gate done");
   endtask : t_gate
   // bit 7 of the priority register is never written with a one
   task automatic t_prio;
      w(iep_pkg::OFS_ENABLE, 32'hff);
      for (int i = 0; i < 7; i++) begin
         w(iep_pkg::OFS_PRIO_LOW, 32'h1 << i);
         repeat (5) @(posedge mclk);
         chk(32'({seen.level, seen.source}), 32'({2'b01, 3'(i)}));
      end
      rdchk(iep_pkg::OFS_PRIO_LOW, 32'h40);
      w(iep_pkg::OFS_PRIO_HIGH, 32'h04);
      repeat (5) @(posedge mclk);
      chk(32'({seen.level, seen.source}), 32'h12);
      w(iep_pkg::OFS_PRIO_HIGH, 32'h00);
      $display("t_prio done");
   endtask : t_prio
   task automatic t_bitop;
      w(iep_pkg::OFS_ENABLE, 32'h81);
      w(iep_pkg::OFS_BIT_OP, 32'h105);
      rdchk(iep_pkg::OFS_ENABLE, 32'ha1);
      w(iep_pkg::OFS_BIT_OP, 32'h007);
      rdchk(iep_pkg::OFS_ENABLE, 32'h21);
      w(iep_pkg::OFS_PRIO_LOW, 32'h00);
      w(iep_pkg::OFS_BIT_OP, 32'h10b);
      rdchk(iep_pkg::OFS_PRIO_LOW, 32'h08);
      w(iep_pkg::OFS_BIT_OP, 32'h112);
      rdchk(iep_pkg::OFS_PRIO_HIGH, 32'h04);
      w(iep_pkg::OFS_BIT_OP, 32'h11b);
      rdchk(iep_pkg::OFS_PRIO_LOW, 32'h08);
      w(iep_pkg::OFS_PRIO_HIGH, 32'h00);
      $display("t_bitop done");
   endtask : t_bitop
   task automatic t_bus;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(8'hf0, d, r);
      chk(32'(r), 32'(iep_pkg::RESP_SLVERR));
      chk(d, 32'h0);
      axi_wr(8'hf0, 32'hff, r);
      chk(32'(r), 32'(iep_pkg::RESP_SLVERR));
      $display("t_bus done");
   endtask : t_bus
   task automatic t_irq;
      @(posedge mclk);
      src <= 7'h00;
      w(iep_pkg::OFS_MASK, 32'h02);
      w(iep_pkg::OFS_STATUS, 32'h7f);
      @(posedge mclk);
      src <= 7'h02;
      repeat (6) @(posedge mclk);
      chk(32'(irq), 32'h1);
      rdchk(iep_pkg::OFS_STATUS, 32'h02);
      w(iep_pkg::OFS_MASK, 32'h00);
      repeat (2) @(posedge mclk);
      chk(32'(irq), 32'h0);
      w(iep_pkg::OFS_MASK, 32'h02);
      repeat (2) @(posedge mclk);
      chk(32'(irq), 32'h1);
      w(iep_pkg::OFS_STATUS, 32'h02);
      repeat (2) @(posedge mclk);
      chk(32'(irq), 32'h0);
      $display("t_irq done");
   endtask : t_irq
   // registers hold non-reset values here, so the re-reset is visible
   task automatic t_rerst;
      @(posedge mclk);
      rst <= 1;
      repeat (3) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      rdchk(iep_pkg::OFS_ENABLE, 32'(iep_pkg::RST_ENABLE));
      rdchk(iep_pkg::OFS_PRIO_LOW, 32'h00);
      $display("t_rerst done");
   endtask : t_rerst
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      t_reset();
      t_gate();
      t_prio();
      t_bitop();
      t_bus();
      t_irq();
      t_rerst();
      stop_test();
   end
endmodule : tb
`default_nettype wire
